// >>> hdl/drive_io_assign.sv
// Purpose: Terminal function assignment and operation data source selection for a motor drive.
// Assumes: Parameter values are plain ports; rst stands for power-on.
// Notes:   Terminal assignments take effect only at reset release, as after power-on.
// Behaviour
// RL1: Speed/torque selector picks speed and torque sources; accel/decel selector picks times.
// RL2: Speed mode, selector 0: all speeds and torque limits digital.
// RL3: Speed mode, selector 1: entry 0 internal pot, entry 1 external; rest digital.
// RL4: Position mode: speed always digital; selector 0 or 1 keeps torque digital.
// RL5: Position mode, selector 2: every torque limit from external pot or voltage.
// RL6: Accel/decel selector honoured only in speed control mode.
// RL7: Accel/decel selector 1: entries 0 and 1 from time pots; else digital.
// RL8: One function code per input terminal routes its level to that function.
// RL9: Input codes decode to their fixed internal functions.
// RL10: Input defaults per control mode, position mode changes terminals 0, 1, 8.
// RL11: Per-terminal inversion before decoding; all default to pass-through.
// RL12: Function selections and logic levels take effect only after power-on.
// RL13: One code per output terminal drives it from the named status.
// RL14: Output defaults 65,68,66 in speed mode; 65,67,70 in position mode.
// RL15: Undefined input codes are treated as unassigned.
`timescale 1ns/1ps
`default_nettype none
module drive_io_assign
   import drive_io_pkg::*;
(
   // Clock and reset
   input  wire logic                                clock,
   input  wire logic                                rst,
   // Mode and source selectors
   input  wire logic                                position_mode,
   input  wire logic [1:0]                          speed_torque_sel,
   input  wire logic                                accel_decel_sel,
   input  wire logic [drive_io_pkg::ENTRY_W-1:0]    entry_sel,
   // Written assignments, adopted only at power-on
   input  wire logic                                use_defaults,
   input  wire logic [drive_io_pkg::N_IN*drive_io_pkg::CODE_W-1:0] in_code_wr,
   input  wire logic [drive_io_pkg::N_IN-1:0]       in_invert_wr,
   input  wire logic [drive_io_pkg::N_OUT*drive_io_pkg::CODE_W-1:0] out_code_wr,
   // Terminals
   input  wire logic [drive_io_pkg::N_IN-1:0]       input_terminal,
   output logic      [drive_io_pkg::N_OUT-1:0]      output_terminal,
   // Drive status and decoded functions
   input  wire       drive_io_pkg::out_stat_t       status,
   output var        drive_io_pkg::in_func_t        funcs,
   // Source of the selected entry
   output var        drive_io_pkg::src_t            speed_src,
   output var        drive_io_pkg::src_t            torque_src,
   output var        drive_io_pkg::src_t            accel_src,
   output var        drive_io_pkg::src_t            decel_src
);
   import drive_io_pkg::*;

   logic [N_IN*CODE_W-1:0]  in_code_q,  in_code_d;
   logic [N_IN-1:0]         inv_q,      inv_d;
   logic [N_OUT*CODE_W-1:0] out_code_q, out_code_d;
   logic                    boot_q,     boot_d;
   logic [N_IN-1:0]         sync1_q,    sync2_q;
   logic [N_OUT-1:0]        out_d,      out_q;
   src_t                    spd_d, trq_d, acc_d, dec_d;
   logic [N_IN-1:0]         cond;

   function automatic logic out_pick(input logic [CODE_W-1:0] c, input out_stat_t s);
      logic r;
      r = 1'b0;
      unique case (c)
         FO_ALARM    : r = s.alarm_out;
         FO_WARNING  : r = s.warning_out;
         FO_READY    : r = s.ready;
         FO_MOVING   : r = s.moving;
         FO_END      : r = s.end_pos;
         FO_HOME_POS : r = s.home_pos;
         FO_TLIM     : r = s.torque_limiting_out;
         FO_SPD_ATT  : r = s.speed_attained_out;
         FO_ZERO_SPD : r = s.zero_speed_out;
         default     : r = 1'b0;
      endcase
      return r;
   endfunction : out_pick

   // Assignment latch: takes the written or default set once after reset release.
   always_comb
   begin
      boot_d     = 1'b0;
      in_code_d  = in_code_q;
      inv_d      = inv_q;
      out_code_d = out_code_q;
      if (boot_q)                                            // [RL12]
      begin
         if (use_defaults)
         begin
            in_code_d  = position_mode ? IN_DEF_POS : IN_DEF_SPEED;     // [RL10]
            out_code_d = position_mode ? OUT_DEF_POS : OUT_DEF_SPEED;   // [RL14]
            inv_d      = INV_DEF;                                       // [RL11]
         end
         else
         begin
            in_code_d  = in_code_wr;                         // [RL8]
            out_code_d = out_code_wr;                        // [RL13]
            inv_d      = in_invert_wr;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         boot_q     <= 1'b1;
         in_code_q  <= IN_DEF_SPEED;
         out_code_q <= OUT_DEF_SPEED;
         inv_q      <= INV_DEF;
      end
      else
      begin
         boot_q     <= boot_d;
         in_code_q  <= in_code_d;
         out_code_q <= out_code_d;
         inv_q      <= inv_d;
      end
   end

   // Terminal pins are asynchronous and pass two flops first.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= input_terminal;
         sync2_q <= sync1_q;
      end
   end

   assign cond = sync2_q ^ inv_q;                            // [RL11]

   input_decode u_dec (
      .level (cond),
      .codes (in_code_q),
      .funcs (funcs)
   );

   // Output terminals and entry sources.
   always_comb
   begin
      for (int k = 0; k < N_OUT; k++)
      begin
         out_d[k] = out_pick(out_code_q[k*CODE_W +: CODE_W], status);   // [RL13]
      end
      spd_d = SRC_DIGITAL;
      trq_d = SRC_DIGITAL;
      acc_d = SRC_DIGITAL;
      dec_d = SRC_DIGITAL;
      if (!position_mode)                                    // [RL1]
      begin
         if (speed_torque_sel == ST_ANALOG)                  // [RL2] [RL3]
         begin
            if (entry_sel == 4'h0)
            begin
               spd_d = SRC_INT_POT;
            end
            else if (entry_sel == 4'h1)
            begin
               spd_d = SRC_EXT_POT;
            end
         end
         if (accel_decel_sel && entry_sel <= 4'h1)           // [RL6] [RL7]
         begin
            acc_d = SRC_TIME_POT;
            dec_d = SRC_TIME_POT;
         end
      end
      else if (speed_torque_sel == ST_TORQUE)                // [RL4] [RL5]
      begin
         trq_d = SRC_EXT_POT;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         out_q      <= '0;
         speed_src  <= SRC_DIGITAL;
         torque_src <= SRC_DIGITAL;
         accel_src  <= SRC_DIGITAL;
         decel_src  <= SRC_DIGITAL;
      end
      else
      begin
         out_q      <= out_d;
         speed_src  <= spd_d;
         torque_src <= trq_d;
         accel_src  <= acc_d;
         decel_src  <= dec_d;
      end
   end

   assign output_terminal = out_q;

   // Checks.
   // The latch edge itself changes the sets, so stability is checked from the second edge after it.
   property p_latch_once;
      @(posedge clock) disable iff (rst)
      !boot_q && !$past(boot_q)
         |-> $stable(in_code_q) && $stable(inv_q) && $stable(out_code_q);
   endproperty
   a_latch_once: assert property (p_latch_once) else $error("set changed after latch"); // [RL12]

   property p_pos_speed;
      @(posedge clock) disable iff (rst)
      position_mode |=> speed_src == SRC_DIGITAL && accel_src == SRC_DIGITAL;
   endproperty
   a_pos_speed: assert property (p_pos_speed) else $error("analog in position mode"); // [RL4]

   property p_pos_torque;
      @(posedge clock) disable iff (rst)
      position_mode && speed_torque_sel == ST_TORQUE |=> torque_src == SRC_EXT_POT;
   endproperty
   a_pos_torque: assert property (p_pos_torque) else $error("torque not external"); // [RL5]

   property p_spd_sel0;
      @(posedge clock) disable iff (rst)
      !position_mode && speed_torque_sel == ST_DIGITAL
         |=> speed_src == SRC_DIGITAL && torque_src == SRC_DIGITAL;
   endproperty
   a_spd_sel0: assert property (p_spd_sel0) else $error("selector 0 not digital"); // [RL2]

   property p_spd_sel1;
      @(posedge clock) disable iff (rst)
      !position_mode && speed_torque_sel == ST_ANALOG && entry_sel == 4'h1
         |=> speed_src == SRC_EXT_POT;
   endproperty
   a_spd_sel1: assert property (p_spd_sel1) else $error("entry 1 not external"); // [RL3]

   property p_acc;
      @(posedge clock) disable iff (rst)
      !position_mode && accel_decel_sel && entry_sel == 4'h0 |=> decel_src == SRC_TIME_POT;
   endproperty
   a_acc: assert property (p_acc) else $error("time pot not used"); // [RL7]

   property p_inv;
      @(posedge clock) disable iff (rst)
      !boot_q && inv_q[7] && in_code_q[55:49] == FN_STOP && !sync2_q[7] |-> funcs.stop;
   endproperty
   a_inv: assert property (p_inv) else $error("inversion lost"); // [RL11]

   property p_out;
      @(posedge clock) disable iff (rst)
      out_code_q[6:0] == FO_ALARM && $stable(out_code_q)
         |=> output_terminal[0] == $past(status.alarm_out);
   endproperty
   a_out: assert property (p_out) else $error("output 0 mismatch"); // [RL13]
endmodule : drive_io_assign
`default_nettype wire

// >>> hdl/drive_io_pkg.sv
// Purpose: Shared constants and types for the drive terminal assignment and source selection.
// Assumes: Parameter values arrive as plain ports; codes follow the terminal function tables.
// Notes:   Defaults differ between speed and position control mode.
package drive_io_pkg;
   localparam int N_IN     = 9;
   localparam int N_OUT    = 3;
   localparam int CODE_W   = 7;
   localparam int N_ENTRY  = 16;
   localparam int ENTRY_W  = 4;

   // Speed/torque source selector values.
   localparam logic [1:0] ST_DIGITAL = 2'h0;
   localparam logic [1:0] ST_ANALOG  = 2'h1;
   localparam logic [1:0] ST_TORQUE  = 2'h2;

   // Input function codes.
   localparam logic [6:0] FN_UNUSED    = 7'h00;
   localparam logic [6:0] FN_FORWARD   = 7'h01;
   localparam logic [6:0] FN_REVERSE   = 7'h02;
   localparam logic [6:0] FN_HOME      = 7'h03;
   localparam logic [6:0] FN_START     = 7'h04;
   localparam logic [6:0] FN_SEQUENTIAL_START    = 7'h05;
   localparam logic [6:0] FN_JOG_PLUS  = 7'h06;
   localparam logic [6:0] FN_JOG_MINUS = 7'h07;
   localparam logic [6:0] FN_SPD_SEL0  = 7'h08;
   localparam logic [6:0] FN_SPD_SEL5  = 7'h0d;
   localparam logic [6:0] FN_FREE      = 7'h10;
   localparam logic [6:0] FN_SERVO_ON  = 7'h11;
   localparam logic [6:0] FN_STOP      = 7'h12;
   localparam logic [6:0] FN_THERMAL   = 7'h16;
   localparam logic [6:0] FN_ALARM_RESET   = 7'h18;
   localparam logic [6:0] FN_PRESET    = 7'h19;
   localparam logic [6:0] FN_INTERLOCK = 7'h1b;
   localparam logic [6:0] FN_DAT_SEL0  = 7'h30;
   localparam logic [6:0] FN_DAT_SEL1  = 7'h31;
   localparam logic [6:0] FN_DAT_SEL2  = 7'h32;
   localparam logic [6:0] FN_DAT_SEL3  = 7'h33;
   localparam logic [6:0] FN_TLIM_SEL  = 7'h36;
   localparam logic [6:0] FN_HOME_SENS = 7'h3e;

   // Output function codes.
   localparam logic [6:0] FO_ALARM    = 7'h41;
   localparam logic [6:0] FO_WARNING  = 7'h42;
   localparam logic [6:0] FO_READY    = 7'h43;
   localparam logic [6:0] FO_MOVING   = 7'h44;
   localparam logic [6:0] FO_END      = 7'h45;
   localparam logic [6:0] FO_HOME_POS = 7'h46;
   localparam logic [6:0] FO_TLIM     = 7'h47;
   localparam logic [6:0] FO_SPD_ATT  = 7'h4d;
   localparam logic [6:0] FO_ZERO_SPD = 7'h55;

   // Default input and output selections, speed mode then position mode, then the inversion default.
   localparam logic [N_IN*CODE_W-1:0] IN_DEF_SPEED =
      {7'h00, 7'h18, 7'h12, 7'h10, 7'h32, 7'h31, 7'h30, 7'h02, 7'h01};
   localparam logic [N_IN*CODE_W-1:0] IN_DEF_POS =
      {7'h3e, 7'h18, 7'h12, 7'h10, 7'h32, 7'h31, 7'h30, 7'h04, 7'h03};
   localparam logic [N_OUT*CODE_W-1:0] OUT_DEF_SPEED = {7'h42, 7'h44, 7'h41};
   localparam logic [N_OUT*CODE_W-1:0] OUT_DEF_POS   = {7'h46, 7'h43, 7'h41};
   localparam logic [N_IN-1:0]         INV_DEF       = 9'h000;

   // Internal functions driven by the input terminals.
   typedef struct packed {
      logic       forward_run;
      logic       reverse_run;
      logic       home_start;
      logic       start;
      logic       sequential_start;
      logic       jog_plus;
      logic       jog_minus;
      logic [5:0] speed_select;
      logic       free_run;
      logic       servo_on;
      logic       stop;
      logic       thermal_input;
      logic       alarm_reset;
      logic       position_preset;
      logic       interlock_release;
      logic [3:0] data_select;
      logic       torque_limit_select;
      logic       home_sensor;
   } in_func_t;

   // Drive status available to the output terminals.
   typedef struct packed {
      logic alarm_out;
      logic warning_out;
      logic ready;
      logic moving;
      logic end_pos;
      logic home_pos;
      logic torque_limiting_out;
      logic speed_attained_out;
      logic zero_speed_out;
   } out_stat_t;

   // Source choice per operation data entry.
   typedef enum logic [1:0] {
      SRC_DIGITAL  = 2'h0,
      SRC_INT_POT  = 2'h1,
      SRC_EXT_POT  = 2'h3,
      SRC_TIME_POT = 2'h2
   } src_t;
endpackage : drive_io_pkg

// >>> hdl/input_decode.sv
// Purpose: Routes conditioned input terminal levels to internal functions by code.
// Assumes: Codes are stable, latched at power-on by the parent.
// Notes:   Codes outside the defined set affect nothing.
`timescale 1ns/1ps
`default_nettype none
module input_decode
   import drive_io_pkg::*;
(
   // Terminals
   input  wire logic [drive_io_pkg::N_IN-1:0]             level,
   input  wire logic [drive_io_pkg::N_IN*drive_io_pkg::CODE_W-1:0] codes,
   // Functions
   output var        drive_io_pkg::in_func_t              funcs
);
   import drive_io_pkg::*;

   always_comb
   begin
      logic [CODE_W-1:0] c;
      c     = '0;
      funcs = '0;
      for (int i = 0; i < N_IN; i++)
      begin
         c = codes[i*CODE_W +: CODE_W];
         if (level[i])
         begin
            unique case (c)                                  // [RL9]
               FN_FORWARD   : funcs.forward_run         = 1'b1;
               FN_REVERSE   : funcs.reverse_run         = 1'b1;
               FN_HOME      : funcs.home_start          = 1'b1;
               FN_START     : funcs.start               = 1'b1;
               FN_SEQUENTIAL_START    : funcs.sequential_start    = 1'b1;
               FN_JOG_PLUS  : funcs.jog_plus            = 1'b1;
               FN_JOG_MINUS : funcs.jog_minus           = 1'b1;
               FN_FREE      : funcs.free_run            = 1'b1;
               FN_SERVO_ON  : funcs.servo_on            = 1'b1;
               FN_STOP      : funcs.stop                = 1'b1;
               FN_THERMAL   : funcs.thermal_input       = 1'b1;
               FN_ALARM_RESET   : funcs.alarm_reset         = 1'b1;
               FN_PRESET    : funcs.position_preset     = 1'b1;
               FN_INTERLOCK : funcs.interlock_release   = 1'b1;
               FN_DAT_SEL0  : funcs.data_select[0]      = 1'b1;
               FN_DAT_SEL1  : funcs.data_select[1]      = 1'b1;
               FN_DAT_SEL2  : funcs.data_select[2]      = 1'b1;
               FN_DAT_SEL3  : funcs.data_select[3]      = 1'b1;
               FN_TLIM_SEL  : funcs.torque_limit_select = 1'b1;
               FN_HOME_SENS : funcs.home_sensor         = 1'b1;
               default :
               begin
                  // Speed select bits 0 to 5; anything else is unassigned. [RL15]
                  if (c >= FN_SPD_SEL0 && c <= FN_SPD_SEL5)
                  begin
                     funcs.speed_select[3'(c - FN_SPD_SEL0)] = 1'b1;
                  end
               end
            endcase
         end
      end
   end
endmodule : input_decode
`default_nettype wire

// >>> tb/host_ctrl.sv
// Purpose: Behavioural host controller that wires the drive's input and output terminals.
// Assumes: The host sets terminal levels at any time; the drive synchronises them through two flops.
// Notes:   Levels are applied as given; output terminals are only observed.
`timescale 1ns/1ps
`default_nettype none
module host_ctrl
   import drive_io_pkg::*;
(
   // Requested contact states
   input  wire logic [drive_io_pkg::N_IN-1:0]  level_req,
   // Terminals
   output logic      [drive_io_pkg::N_IN-1:0]  input_terminal,
   input  wire logic [drive_io_pkg::N_OUT-1:0] output_terminal,
   output logic      [drive_io_pkg::N_OUT-1:0] seen_out
);
   assign input_terminal = level_req;
   assign seen_out       = output_terminal;
endmodule : host_ctrl
`default_nettype wire

// >>> tb/drive_io_assign_and_source_select_test.sv
// Purpose: Self-checking bench for terminal assignment and source selection.
// Assumes: Inputs change at the falling edge; results are settled four cycles later.
// Notes:   Assignment ports are scrambled after every latch to show they are ignored.
`timescale 1ns/1ps
`default_nettype none
module drive_io_assign_and_source_select_test;
   import drive_io_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic position_mode = 1'b0;
   logic [1:0] speed_torque_sel = 2'h0;
   logic accel_decel_sel = 1'b0;
   logic [3:0] entry_sel = 4'h0;
   logic use_defaults = 1'b1;
   logic [N_IN*CODE_W-1:0] in_code_wr = '0;
   logic [N_IN-1:0] in_invert_wr = '0;
   logic [N_OUT*CODE_W-1:0] out_code_wr = '0;
   logic [N_IN-1:0] level_req = '0;
   logic [N_IN-1:0] input_terminal;
   logic [N_OUT-1:0] output_terminal;
   logic [N_OUT-1:0] seen_out;
   out_stat_t status = '0;
   in_func_t funcs;
   src_t speed_src, torque_src, accel_src, decel_src;
   logic [N_IN*CODE_W-1:0] codes_m;
   logic [N_IN-1:0] inv_m;
   logic [N_OUT*CODE_W-1:0] ocodes_m;
   int n_errors = 0;
   int tests_run = 0;
   int icodes [27] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 16, 17, 18, 22, 24, 25,
                       27, 48, 49, 50, 51, 54, 62};
   int ocodes [10] = '{65, 66, 67, 68, 69, 70, 71, 77, 85, 127};

   always #25 clock = ~clock;

   drive_io_assign dut (.clock(clock), .rst(rst), .position_mode(position_mode),
      .speed_torque_sel(speed_torque_sel), .accel_decel_sel(accel_decel_sel),
      .entry_sel(entry_sel), .use_defaults(use_defaults), .in_code_wr(in_code_wr),
      .in_invert_wr(in_invert_wr), .out_code_wr(out_code_wr),
      .input_terminal(input_terminal), .output_terminal(output_terminal), .status(status),
      .funcs(funcs), .speed_src(speed_src), .torque_src(torque_src), .accel_src(accel_src),
      .decel_src(decel_src));

   host_ctrl host (.level_req(level_req), .input_terminal(input_terminal),
      .output_terminal(output_terminal), .seen_out(seen_out));

   function automatic in_func_t exp_funcs(input logic [N_IN*CODE_W-1:0] c,
                                          input logic [N_IN-1:0] inv, lv);
      in_func_t e;
      logic b;
      int k;
      e = '0;
      for (int i = 0; i < N_IN; i++)
      begin
         b = lv[i] ^ inv[i];
         k = int'(c[7*i +: 7]);
         case (k) inside
            1: e.forward_run |= b;
            2: e.reverse_run |= b;
            3: e.home_start |= b;
            4: e.start |= b;
            5: e.sequential_start |= b;
            6: e.jog_plus |= b;
            7: e.jog_minus |= b;
            [8:13]: e.speed_select[k-8] |= b;
            16: e.free_run |= b;
            17: e.servo_on |= b;
            18: e.stop |= b;
            22: e.thermal_input |= b;
            24: e.alarm_reset |= b;
            25: e.position_preset |= b;
            27: e.interlock_release |= b;
            [48:51]: e.data_select[k-48] |= b;
            54: e.torque_limit_select |= b;
            62: e.home_sensor |= b;
            default: ;
         endcase
      end
      return e;
   endfunction : exp_funcs

   function automatic logic exp_out(input logic [6:0] c, input out_stat_t s);
      case (c)
         7'h41: return s.alarm_out;
         7'h42: return s.warning_out;
         7'h43: return s.ready;
         7'h44: return s.moving;
         7'h45: return s.end_pos;
         7'h46: return s.home_pos;
         7'h47: return s.torque_limiting_out;
         7'h4d: return s.speed_attained_out;
         7'h55: return s.zero_speed_out;
         default: return 1'b0;
      endcase
   endfunction : exp_out

   task automatic chk_funcs(input in_func_t e);
      tests_run++;
      if (funcs !== e)
      begin
         n_errors++;
         $display("MISMATCH funcs expected %h seen %h", e, funcs);
      end
   endtask : chk_funcs

   task automatic chk_out(input logic [N_OUT-1:0] e);
      tests_run++;
      if (output_terminal !== e)
      begin
         n_errors++;
         $display("MISMATCH output_terminal expected %h seen %h", e, output_terminal);
      end
   endtask : chk_out

   task automatic chk_src(input string name, input src_t e, input src_t s);
      tests_run++;
      if (s !== e)
      begin
         n_errors++;
         $display("MISMATCH %s expected %0d seen %0d", name, e, s);
      end
   endtask : chk_src

   task automatic do_reset(input logic pm, ud, input logic [N_IN*CODE_W-1:0] c,
                           input logic [N_IN-1:0] inv, input logic [N_OUT*CODE_W-1:0] oc);
      @(negedge clock);
      rst = 1'b1;
      position_mode = pm;
      use_defaults = ud;
      in_code_wr = c;
      in_invert_wr = inv;
      out_code_wr = oc;
      codes_m = ud ? (pm ? IN_DEF_POS : IN_DEF_SPEED) : c;
      inv_m = ud ? INV_DEF : inv;
      ocodes_m = ud ? (pm ? OUT_DEF_POS : OUT_DEF_SPEED) : oc;
      repeat (10) @(negedge clock);
      chk_out(3'h0);
      rst = 1'b0;
      @(negedge clock);
   endtask : do_reset

   task automatic step();
      logic [N_OUT-1:0] eo;
      src_t es, et, ea;
      level_req = 9'($urandom);
      status = 9'($urandom);
      in_code_wr = {31'($urandom), 32'($urandom)};
      in_invert_wr = 9'($urandom);
      out_code_wr = 21'($urandom);
      use_defaults = 1'($urandom);
      repeat (4) @(negedge clock);
      for (int k = 0; k < N_OUT; k++)
         eo[k] = exp_out(ocodes_m[7*k +: 7], status);
      es = (!position_mode && speed_torque_sel == ST_ANALOG && entry_sel < 4'h2) ?
           ((entry_sel == 4'h0) ? SRC_INT_POT : SRC_EXT_POT) : SRC_DIGITAL;
      et = (position_mode && speed_torque_sel == ST_TORQUE) ? SRC_EXT_POT : SRC_DIGITAL;
      ea = (!position_mode && accel_decel_sel && entry_sel < 4'h2) ? SRC_TIME_POT : SRC_DIGITAL;
      chk_funcs(exp_funcs(codes_m, inv_m, level_req));
      chk_out(eo);
      chk_src("speed_src", es, speed_src);
      chk_src("torque_src", et, torque_src);
      chk_src("accel_src", ea, accel_src);
      chk_src("decel_src", ea, decel_src);
   endtask : step

   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results

   initial
   begin
      #(50 * 5000);
      n_errors++;
      results();
   end

   initial
   begin
      logic [N_IN*CODE_W-1:0] c;
      logic [N_OUT*CODE_W-1:0] oc;
      int j;
      void'($urandom(32'h3db6));
      do_reset(1'b0, 1'b1, '0, '0, '0);
      repeat (20) step();
      $display("test 1 speed mode defaults done");
      do_reset(1'b1, 1'b1, '0, '0, '0);
      repeat (20) step();
      $display("test 2 position mode defaults done");
      for (int r = 0; r < 4; r++)
      begin
         for (int i = 0; i < N_IN; i++)
         begin
            j = 9 * r + i;
            c[7*i +: 7] = (j < 27) ? 7'(icodes[j]) : 7'(8'h60 + i);
         end
         for (int k = 0; k < N_OUT; k++)
            oc[7*k +: 7] = 7'(ocodes[(3 * r + k) % 10]);
         // The second set puts the stop code on terminal 7; inverting it exercises the inversion.
         do_reset(1'($urandom), 1'b0, c, 9'($urandom) | ((r == 1) ? 9'h080 : 9'h000), oc);
         repeat (8) step();
      end
      $display("test 3 written codes and inversion done");
      do_reset(1'b0, 1'b1, '0, '0, '0);
      for (int pm = 0; pm < 2; pm++)
         for (int s = 0; s < 3; s++)
            for (int a = 0; a < 2; a++)
               for (int e = 0; e < N_ENTRY; e++)
               begin
                  position_mode = 1'(pm);
                  speed_torque_sel = 2'(s);
                  accel_decel_sel = 1'(a);
                  entry_sel = 4'(e);
                  step();
               end
      $display("test 4 source selection done");
      results();
   end
endmodule : drive_io_assign_and_source_select_test
`default_nettype wire
